// [vde_consts.svh]
// Offsets, field positions and special codes of the virtual completion block.
// Assumes inclusion by bare name from package and design files.
`ifndef VDE_CONSTS_SVH
`define VDE_CONSTS_SVH

`define VDE_OFF_EOI_GRP0    16'h0010
`define VDE_OFF_PEEK_GRP0   16'h0018
`define VDE_OFF_DEACT_ID    16'h1000

`define VDE_ID_LSB          0
`define VDE_ID_MSB          9
`define VDE_SRC_LSB         10
`define VDE_SRC_MSB         12

`define VDE_ID_SPECIAL_BASE 10'h3fc
`define VDE_ID_SPUR_GRP1    10'h3fe
`define VDE_ID_SPUR_NONE    10'h3ff
`define VDE_ID_SGI_LIMIT    10'h010

`define VDE_ST_INACTIVE     2'h0
`define VDE_ST_PENDING      2'h1
`define VDE_ST_ACTIVE       2'h2
`define VDE_ST_ACT_PEND     2'h3
`define VDE_ST_ACTIVE_BIT   1
`define VDE_ST_PENDING_BIT  0

`define VDE_APR_RESET       32'h0000_0000
`define VDE_MISS_RESET      5'h00

`endif

// [vde_pkg.sv]
// Types shared by the virtual completion block and its surroundings.
// Assumes vde_consts.svh on the include path.
`include "vde_consts.svh"

package vde_pkg;

   // One list-register entry as seen by this block
   typedef struct packed {
      logic [1:0] st;
      logic       hw;
      logic       grp;
      logic [4:0] prio;
      logic [2:0] src;
      logic [9:0] pid;
      logic [9:0] vid;
   } vde_lr_t;

   // Deactivate request to the physical distributor
   typedef struct packed {
      logic       nonsecure;
      logic [9:0] pid;
   } vde_phys_req_t;

endpackage

// [vde_virt_completion.sv]
// Deactivate, end-of-interrupt and pending-peek logic of a virtual
// processor interface, with the list registers it works on.
// Assumes one register access per cycle and a hypervisor loading entries.
`timescale 1ns/10ps
`include "vde_consts.svh"

module vde_virt_completion
   import vde_pkg::*;
#(
   parameter int NUM_LR     = 4,
   parameter bit SINGLE_SEC = 1'b0
)(
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [15:0]                   reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_secure,
   output logic      [31:0]                   reg_rdata,
   input  wire logic                          split_completion_mode,
   input  wire logic                          acknowledge_control_bit,
   input  wire logic                          lr_load,
   input  wire logic [$clog2(NUM_LR)-1:0]     lr_load_idx,
   input  wire vde_lr_t                       lr_load_data,
   input  wire logic                          ack_req,
   output logic      [9:0]                    ack_id,
   output vde_lr_t   [NUM_LR-1:0]             list_register_entry,
   output logic      [31:0]                   active_priorities_register,
   output logic      [4:0]                    completion_miss_counter,
   output logic                               phys_deact_valid,
   output vde_phys_req_t                      phys_deact_req
);

   localparam int IW = $clog2(NUM_LR);

   vde_lr_t [NUM_LR-1:0] lr_reg;
   logic [31:0]          apr_reg;
   logic [4:0]           miss_reg;
   logic [31:0]          rdata_reg;
   logic [9:0]           ack_id_reg;
   logic                 phys_vld_reg;
   vde_phys_req_t        phys_req_reg;

   logic [9:0]           wr_id;
   logic [2:0]           wr_src;
   logic                 wr_special;
   logic                 dir_wr;
   logic                 eoi_wr;
   logic                 peek_rd;
   logic                 do_deact;
   logic                 ack_take;
   logic                 secure_eff;
   logic [NUM_LR-1:0]    hit;
   logic [NUM_LR-1:0]    pend;
   logic                 hit_any;
   logic [IW-1:0]        hit_idx;
   logic                 hit_active;
   logic                 best_vld;
   logic [IW-1:0]        best_idx;
   logic [31:0]          apr_low;
   logic [31:0]          peek_val;

   // Only the low identifier bits and the source field matter here
   assign wr_id      = reg_wdata[`VDE_ID_MSB:`VDE_ID_LSB];
   assign wr_src     = reg_wdata[`VDE_SRC_MSB:`VDE_SRC_LSB];
   assign wr_special = (wr_id >= `VDE_ID_SPECIAL_BASE);
   assign dir_wr     = reg_wr && (reg_addr == `VDE_OFF_DEACT_ID);
   assign eoi_wr     = reg_wr && (reg_addr == `VDE_OFF_EOI_GRP0);
   assign peek_rd    = reg_rd && (reg_addr == `VDE_OFF_PEEK_GRP0);
   assign secure_eff = reg_secure || SINGLE_SEC;

   // Deactivate outside split mode is undefined; it is dropped here
   assign do_deact = !wr_special &&
                     ((dir_wr && split_completion_mode) ||
                      (eoi_wr && !split_completion_mode));

   // Writes and list loads win over a same-cycle acknowledge
   assign ack_take = ack_req && !reg_wr && !lr_load;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LR; gi++) begin : g_entry
         // Sender field only tells software interrupts apart
         assign hit[gi] = (lr_reg[gi].st != `VDE_ST_INACTIVE) &&
                          (lr_reg[gi].vid == wr_id) &&
                          (lr_reg[gi].hw || lr_reg[gi].vid >= `VDE_ID_SGI_LIMIT ||
                           lr_reg[gi].src == wr_src);
         assign pend[gi] = (lr_reg[gi].st == `VDE_ST_PENDING);
      end
   endgenerate

   always_comb begin
      hit_any  = 1'b0;
      hit_idx  = '0;
      best_vld = 1'b0;
      best_idx = '0;
      for (int i = 0; i < NUM_LR; i++) begin
         if (hit[i] && !hit_any) begin
            hit_any = 1'b1;
            hit_idx = IW'(i);
         end
         // Lower value is higher priority; ties go to the lower index
         if (pend[i] && (!best_vld || lr_reg[i].prio < lr_reg[best_idx].prio)) begin
            best_vld = 1'b1;
            best_idx = IW'(i);
         end
      end
   end

   // Only the first match acts; a duplicated identifier is a hypervisor fault
   assign hit_active = hit_any && lr_reg[hit_idx].st[`VDE_ST_ACTIVE_BIT];
   // Lowest set bit is the highest running priority
   assign apr_low    = apr_reg & (~apr_reg + 32'h0000_0001);

   // Query is combinational from the entries; the read flop adds one cycle
   always_comb begin
      peek_val = {22'h0, `VDE_ID_SPUR_NONE};
      if (best_vld) begin
         if (lr_reg[best_idx].grp) begin
            if (!secure_eff || acknowledge_control_bit) begin
               peek_val = {19'h0,
                           lr_reg[best_idx].hw ? 3'h0 : lr_reg[best_idx].src,
                           lr_reg[best_idx].vid};
            end else begin
               peek_val = {22'h0, `VDE_ID_SPUR_GRP1};
            end
         end else if (secure_eff) begin
            peek_val = {19'h0,
                        lr_reg[best_idx].hw ? 3'h0 : lr_reg[best_idx].src,
                        lr_reg[best_idx].vid};
         end
      end
   end

   // List registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lr_reg <= '0;
      end else if (lr_load) begin
         lr_reg[lr_load_idx] <= lr_load_data;
      end else if (do_deact && hit_active) begin
         // Active to inactive, active-and-pending to pending
         lr_reg[hit_idx].st[`VDE_ST_ACTIVE_BIT] <= 1'b0;
      end else if (ack_take && best_vld) begin
         lr_reg[best_idx].st <= `VDE_ST_ACTIVE;
      end
      // Matched but not active: left untouched as the safe choice
   end

   // Active priorities
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         apr_reg <= `VDE_APR_RESET;
      end else if (eoi_wr && !wr_special) begin
         apr_reg <= apr_reg & ~apr_low;
      end else if (ack_take && best_vld) begin
         apr_reg[lr_reg[best_idx].prio] <= 1'b1;
      end
   end

   // Completion misses wrap; the hypervisor reads and resets its copy
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         miss_reg <= `VDE_MISS_RESET;
      end else if (do_deact && !hit_any) begin
         miss_reg <= miss_reg + 5'h01;
      end
   end

   // Physical deactivate, always issued as a non-secure request
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phys_vld_reg <= 1'b0;
         phys_req_reg <= '0;
      end else begin
         phys_vld_reg <= do_deact && hit_active && lr_reg[hit_idx].hw;
         if (do_deact && hit_active && lr_reg[hit_idx].hw) begin
            phys_req_reg.nonsecure <= 1'b1;
            phys_req_reg.pid       <= lr_reg[hit_idx].pid;
         end
      end
   end

   // Read data: peek has no side effect; other offsets read zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_reg <= peek_rd ? peek_val : 32'h0000_0000;
      end
   end

   // With nothing pending an acknowledge reports 1023 and changes nothing
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_id_reg <= `VDE_ID_SPUR_NONE;
      end else if (ack_take) begin
         ack_id_reg <= best_vld ? lr_reg[best_idx].vid : `VDE_ID_SPUR_NONE;
      end
   end

   assign reg_rdata                  = rdata_reg;
   assign ack_id                     = ack_id_reg;
   assign list_register_entry        = lr_reg;
   assign active_priorities_register = apr_reg;
   assign completion_miss_counter    = miss_reg;
   assign phys_deact_valid           = phys_vld_reg;
   assign phys_deact_req             = phys_req_reg;

   sequence s_deact_hit;
      do_deact && hit_active && !lr_load;
   endsequence

   sequence s_deact_miss;
      do_deact && !hit_any;
   endsequence

   dir_deact_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_deact_hit |=> !lr_reg[$past(hit_idx)].st[`VDE_ST_ACTIVE_BIT])
      else $error("deactivate left entry active");

   miss_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_deact_miss |=> (miss_reg == $past(miss_reg) + 5'h01))
      else $error("miss counter not incremented");

   phys_fwd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_deact_hit and lr_reg[hit_idx].hw) |=>
         (phys_deact_valid && phys_deact_req.nonsecure &&
          phys_deact_req.pid == $past(lr_reg[hit_idx].pid)))
      else $error("physical deactivate missing or wrong");

   phys_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      phys_deact_valid |-> $past(do_deact) ##1 !phys_deact_valid or
                           $past(do_deact))
      else $error("physical deactivate without cause");

   split_no_deact_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (eoi_wr && split_completion_mode && !lr_load) |=>
         (!phys_deact_valid && $stable(lr_reg) && $stable(miss_reg)))
      else $error("split mode completion deactivated");

   eoi_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (eoi_wr && !wr_special) |=>
         (apr_reg == ($past(apr_reg) & ($past(apr_reg) - 32'h0000_0001))))
      else $error("priority drop wrong");

   special_ignore_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && wr_special && !lr_load) |=>
         ($stable(lr_reg) && $stable(miss_reg) && $stable(apr_reg) && !phys_deact_valid))
      else $error("special identifier acted on");

   peek_none_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (peek_rd && !best_vld) |=> (reg_rdata == 32'h0000_03ff))
      else $error("empty peek not 1023");

   peek_grp1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (peek_rd && best_vld && lr_reg[best_idx].grp && secure_eff &&
       !acknowledge_control_bit) |=> (reg_rdata == 32'h0000_03fe))
      else $error("secure group 1 peek not 1022");

   peek_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (peek_rd && !reg_wr && !lr_load && !ack_req) |=>
         ($stable(lr_reg) && $stable(apr_reg)))
      else $error("peek changed state");

   ack_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ack_take && best_vld) |=>
         (apr_reg[$past(lr_reg[best_idx].prio)] &&
          lr_reg[$past(best_idx)].st == `VDE_ST_ACTIVE))
      else $error("acknowledge did not activate");

   // A list load in the same cycle overrides the entry update, so it is left out
   sequence s_eoi_combined;
      eoi_wr && !split_completion_mode && !wr_special && hit_active && !lr_load;
   endsequence

   sequence s_dir_unsplit;
      dir_wr && !split_completion_mode && !lr_load;
   endsequence

   eoi_deact_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_eoi_combined |=>
         (!lr_reg[$past(hit_idx)].st[`VDE_ST_ACTIVE_BIT] &&
          phys_deact_valid == $past(lr_reg[hit_idx].hw)))
      else $error("combined completion did not deactivate");

   dir_mode0_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_dir_unsplit |=>
         ($stable(lr_reg) && $stable(miss_reg) && $stable(apr_reg) && !phys_deact_valid))
      else $error("deactivate outside split mode acted");

   inactive_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (do_deact && hit_any && !hit_active && !lr_load) |=>
         ($stable(lr_reg) && $stable(miss_reg) && !phys_deact_valid))
      else $error("non-active match changed state");

   peek_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      peek_rd |=> (reg_rdata[31:`VDE_SRC_MSB+1] == 19'h0))
      else $error("peek reserved bits not zero");

   peek_grp0_ns_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (peek_rd && best_vld && !lr_reg[best_idx].grp && !secure_eff) |=>
         (reg_rdata == 32'h0000_03ff))
      else $error("non-secure group 0 peek not 1023");

   peek_grp1_ns_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (peek_rd && best_vld && lr_reg[best_idx].grp && !secure_eff) |=>
         (reg_rdata[`VDE_ID_MSB:`VDE_ID_LSB] == $past(lr_reg[best_idx].vid)))
      else $error("non-secure group 1 peek lost identifier");

   rdata_other_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && !peek_rd) |=> (reg_rdata == 32'h0000_0000))
      else $error("read of write-only offset not zero");

   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

endmodule

// [vde_dist_model.sv]
// Physical distributor stand-in: takes deactivate requests and keeps the last.
// Assumes requests arrive as registered one-cycle pulses, never stalled.
`timescale 1ns/10ps

module vde_dist_model
   import vde_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          phys_deact_valid,
   input  wire vde_phys_req_t phys_deact_req,
   output int                 req_count,
   output logic [9:0]         last_pid,
   output logic               last_ns
);
   // No backpressure: a pulse is taken on the edge that sees it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_count <= 0;
         last_pid <= 10'h000;
         last_ns <= 1'b0;
      end else if (phys_deact_valid === 1'b1) begin
         req_count <= req_count + 1;
         last_pid <= phys_deact_req.pid;
         last_ns <= phys_deact_req.nonsecure;
      end
   end
endmodule

// [tb_top.sv]
// Self-checking bench for the virtual completion block.
// Assumes the block's package and constants header on the include path.
`timescale 1ns/10ps
`include "vde_consts.svh"

module tb_top
   import vde_pkg::*;
;
   logic          sys_clk, sys_rst, reg_wr, reg_rd, reg_secure, ack_req;
   logic          split_completion_mode, acknowledge_control_bit, lr_load;
   logic [15:0]   reg_addr;
   logic [31:0]   reg_wdata, reg_rdata, apr;
   logic [1:0]    lr_load_idx;
   vde_lr_t       lr_load_data;
   vde_lr_t [3:0] lre;
   logic [9:0]    ack_id, last_pid, v0;
   logic [4:0]    miss;
   logic          pv, last_ns, sm, ac;
   vde_phys_req_t preq;
   int            mismatches, total_checks, cnt, i, seed;

   vde_virt_completion u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_secure(reg_secure),
      .reg_rdata(reg_rdata), .split_completion_mode(split_completion_mode),
      .acknowledge_control_bit(acknowledge_control_bit), .lr_load(lr_load),
      .lr_load_idx(lr_load_idx), .lr_load_data(lr_load_data), .ack_req(ack_req),
      .ack_id(ack_id), .list_register_entry(lre), .active_priorities_register(apr),
      .completion_miss_counter(miss), .phys_deact_valid(pv), .phys_deact_req(preq));
   vde_dist_model u_dist (.sys_clk(sys_clk), .sys_rst(sys_rst), .phys_deact_valid(pv),
      .phys_deact_req(preq), .req_count(cnt), .last_pid(last_pid), .last_ns(last_ns));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // k: 0 write, 1 read (d[0] secure), 2 acknowledge, 3 entry load (a = index)
   task automatic op(input int k, input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= (k == 0);
      reg_rd <= (k == 1);
      ack_req <= (k == 2);
      lr_load <= (k == 3);
      reg_addr <= a;
      lr_load_idx <= a[1:0];
      reg_wdata <= d;
      lr_load_data <= d;
      reg_secure <= d[0];
      split_completion_mode <= sm;
      acknowledge_control_bit <= ac;
      @(posedge sys_clk);
      {reg_wr, reg_rd, ack_req, lr_load} <= 4'h0;
      #1;
   endtask

   function automatic vde_lr_t mk(input logic [1:0] s, input logic h, g,
                                  input logic [4:0] p, input logic [9:0] pid, vid);
      return '{s, h, g, p, 3'h0, pid, vid};
   endfunction

   function automatic logic [31:0] pk(input logic g, s, a, input logic [9:0] v);
      if (g)
         return (!s || a) ? {22'h0, v} : 32'h0000_03fe;
      return s ? {22'h0, v} : 32'h0000_03ff;
   endfunction

   // Watchdog: the run is short, so a stall here means a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      wrap_up();
   end

   initial begin
      seed = 92;
      {reg_wr, reg_rd, reg_secure, ack_req, lr_load, sm, ac} = 7'h00;
      {split_completion_mode, acknowledge_control_bit} = 2'h0;
      {reg_addr, reg_wdata, lr_load_idx, lr_load_data} = 82'h0;
      sys_rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      chk(ack_id, 32'h3ff);
      chk(apr, 32'h0);
      chk(miss, 32'h0);
      for (i = 0; i < 8; i++) begin
         v0 = 10'd16 + 10'({$random(seed)} % 100);
         op(3, 16'h0000, mk(2'h1, 1'b1, i[2], 5'h03, 10'h0aa, v0));
         ac = i[0];
         op(1, `VDE_OFF_PEEK_GRP0, {31'h0, i[1]});
         chk(reg_rdata, pk(i[2], i[1], i[0], v0));
         chk(lre[0].st, 32'h1);
      end
      op(1, `VDE_OFF_EOI_GRP0, 32'h1);
      chk(reg_rdata, 32'h0);
      op(3, 16'h0000, mk(2'h0, 1'b1, 1'b0, 5'h03, 10'h0aa, v0));
      op(1, `VDE_OFF_PEEK_GRP0, 32'h1);
      chk(reg_rdata, 32'h3ff);
      $display("peek table done");
      ac = 1'b0;
      v0 = 10'd16 + 10'({$random(seed)} % 100);
      op(3, 16'h0000, mk(2'h1, 1'b1, 1'b0, 5'h02, 10'h155, v0));
      op(3, 16'h0001, mk(2'h1, 1'b1, 1'b0, 5'h07, 10'h2aa, v0 + 10'd200));
      op(2, 16'h0000, 32'h0);
      chk(ack_id, v0);
      chk(apr, 32'h4);
      op(2, 16'h0000, 32'h0);
      chk(apr, 32'h84);
      chk(lre[1].st, 32'h2);
      op(0, `VDE_OFF_EOI_GRP0, 32'hffff_e000 | v0);
      chk(apr, 32'h80);
      chk(lre[0].st, 32'h0);
      @(posedge sys_clk);
      #1;
      chk(cnt, 32'h1);
      chk({last_ns, last_pid}, 32'h555);
      $display("combined completion done");
      sm = 1'b1;
      op(0, `VDE_OFF_EOI_GRP0, v0 + 10'd200);
      chk(apr, 32'h0);
      chk(lre[1].st, 32'h2);
      chk(cnt, 32'h1);
      op(0, `VDE_OFF_DEACT_ID, v0 + 10'd200);
      chk(lre[1].st, 32'h0);
      @(posedge sys_clk);
      #1;
      chk(cnt, 32'h2);
      chk(last_pid, 32'h2aa);
      op(3, 16'h0002, mk(2'h3, 1'b0, 1'b1, 5'h04, 10'h000, v0 + 10'd400));
      op(0, `VDE_OFF_DEACT_ID, v0 + 10'd400);
      chk(lre[2].st, 32'h1);
      @(posedge sys_clk);
      #1;
      chk(cnt, 32'h2);
      op(0, `VDE_OFF_DEACT_ID, v0 + 10'd600);
      chk(miss, 32'h1);
      op(0, `VDE_OFF_DEACT_ID, 32'h3fd);
      chk(miss, 32'h1);
      $display("split completion done");
      op(0, `VDE_OFF_DEACT_ID, v0 + 10'd400);
      chk(lre[2].st, 32'h1);
      chk(miss, 32'h1);
      op(3, 16'h0003, mk(2'h2, 1'b0, 1'b0, 5'h01, 10'h000, 10'h005) | 32'h0050_0000);
      op(0, `VDE_OFF_DEACT_ID, 32'h0000_0c05);
      chk(miss, 32'h2);
      chk(lre[3].st, 32'h2);
      sm = 1'b0;
      op(0, `VDE_OFF_DEACT_ID, 32'h0000_1405);
      chk(lre[3].st, 32'h2);
      chk(miss, 32'h2);
      sm = 1'b1;
      op(0, `VDE_OFF_DEACT_ID, 32'hfeff_f405);
      chk(lre[3].st, 32'h0);
      chk(miss, 32'h2);
      $display("corner cases done");
      wrap_up();
   end
endmodule
